/* File: rtl/iev_core.sv */
// Vector assignment and source qualification for interrupts and exceptions.
// Assumes the core offers events for one boundary per BOUNDARY_IN pulse,
// holds off boundaries while BUSY_OUT is high, and that the request pins
// are asynchronous while all other inputs are on the core clock.
`default_nettype none

// Contract
// - Math, SIMD and virtualization vectors 16, 19, 20 are faults, no error code.
// - Alignment check uses vector 17 as a fault, pushing error code zero.
// - Vector 20 raised only when the page-table violation control is enabled.
// - Vectors 32 to 255 are user interrupts from external or software sources.
// - Machine check signals an abort on vector 18; error code model dependent.
// - Processors send each other interrupts; every receiver accepts them. Here messages are refused while one is pending or the local controller is off.
// - Without a local controller, dedicated maskable and nonmaskable pins serve.
// - Reset, flush, stop-clock, management, run/stop, init bypass vectoring.
// - Pin and local controller interrupts are maskable; ranges 0-255 and 16-255.
// - A clear interrupt-enable flag masks all maskable hardware interrupts.
// - Local controller reports illegal vector when given vectors 0 to 15.
// - Software interrupt accepts any vector 0-255 and calls its handler.
// - Software interrupt to vector 2 calls handler without nonmaskable hardware.
// - Software interrupts are never masked by the interrupt-enable flag.
// - Software interrupt to an exception vector pushes no error code.
// - Overflow, bound and breakpoint instructions raise exceptions in software.
// - Asserted maskable pin makes the device fetch the vector from the bus.
// - Every true nonmaskable interrupt is delivered through vector 2.
// - Faults restart at the faulting instruction with state restored.
module iev_core #(
    parameter bit HAS_LOCAL_CTRL = 1'b1
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic BOUNDARY_IN,
    input wire logic IF_FLAG_IN,
    input wire logic MASKABLE_REQUEST_PIN_IN,
    input wire logic NMI_PIN_IN,
    input wire logic [7:0] EXT_VECTOR_IN,
    input wire logic EXT_VECTOR_VALID_IN,
    input wire logic LOCAL_CTRL_ENABLE_IN,
    input wire logic LOCAL_MSG_VALID_IN,
    input wire logic LOCAL_MSG_NMI_IN,
    input wire logic [7:0] LOCAL_MSG_VECTOR_IN,
    input wire logic SW_INT_VALID_IN,
    input wire logic [1:0] SW_INT_KIND_IN,
    input wire logic [7:0] SW_INT_VECTOR_IN,
    input wire logic SW_CHECK_FAIL_IN,
    input wire logic MATH_ERR_IN,
    input wire logic ALIGN_ERR_IN,
    input wire logic SIMD_ERR_IN,
    input wire logic EPT_VIOLATION_IN,
    input wire logic VE_ENABLE_IN,
    input wire logic MACHINE_CHECK_IN,
    input wire logic MC_ERR_CODE_VALID_IN,
    input wire logic [31:0] MC_ERR_CODE_IN,
    input wire logic [5:0] SIDEBAND_REQ_IN,
    output logic DISPATCH_VALID_OUT,
    output logic [7:0] DISPATCH_VECTOR_OUT,
    output logic [1:0] DISPATCH_CLASS_OUT,
    output logic PUSH_ERR_CODE_OUT,
    output logic [31:0] ERR_CODE_OUT,
    output logic RESTART_AT_FAULT_OUT,
    output logic NMI_HW_OUT,
    output logic INTA_OUT,
    output logic BUSY_OUT,
    output logic LOCAL_MSG_READY_OUT,
    output logic ILLEGAL_VECTOR_OUT,
    output logic [5:0] SIDEBAND_OUT
);

    localparam iev_pkg::iev_state_s CORE_RST = '{
        st: iev_pkg::ST_IDLE,
        nmi_pend: 1'b0,
        nmi_lvl_d: 1'b0,
        loc_pend: 1'b0,
        loc_vec: iev_pkg::VEC_RESET,
        disp_valid: 1'b0,
        disp_vec: iev_pkg::VEC_RESET,
        disp_class: iev_pkg::CLS_FAULT,
        push_err: 1'b0,
        err_code: iev_pkg::ERR_RESET,
        restart_fault: 1'b0,
        nmi_hw: 1'b0,
        inta: 1'b0,
        illegal: 1'b0,
        sideband: '0
    };

    iev_pkg::iev_state_s cur;
    iev_pkg::iev_state_s next_cur;

    logic local_mode;
    logic msg_ready;
    logic msg_take;
    logic msg_illegal;
    logic msg_maskable;
    logic nmi_set;
    logic take;
    logic ve_fault;
    logic hw_fault;
    logic sw_evt;
    logic pin_req;
    logic g_mc;
    logic g_fault;
    logic g_sw;
    logic g_nmi;
    logic g_loc;
    logic g_pin;
    iev_pkg::iev_sw_kind_e sw_kind;

    iev_pin_if #(.W(iev_pkg::PIN_COUNT)) pins ();

    // Request pins come from outside the clock domain; one driver for the
    // whole vector, slot order is PIN_MASKABLE_REQUEST_PIN at bit 0 and PIN_NMI at bit 1
    assign pins.raw = {NMI_PIN_IN, MASKABLE_REQUEST_PIN_IN};

    iev_pin_sync #(.W(iev_pkg::PIN_COUNT)) u_pin_sync (
        .clk_in(CORE_CLK_IN),
        .reset_n_in(RESET_N_IN),
        .pins(pins)
    );

    // Message path: router and peer processors, refused while full or while the local controller is off
    assign local_mode = HAS_LOCAL_CTRL && LOCAL_CTRL_ENABLE_IN;
    assign msg_ready = local_mode && !cur.loc_pend;
    assign msg_take = LOCAL_MSG_VALID_IN && msg_ready;
    assign msg_illegal = msg_take && !LOCAL_MSG_NMI_IN
        && (LOCAL_MSG_VECTOR_IN < iev_pkg::VEC_LOCAL_MIN);
    assign msg_maskable = msg_take && !LOCAL_MSG_NMI_IN && !msg_illegal;
    assign nmi_set = (pins.lvl[iev_pkg::PIN_NMI] && !cur.nmi_lvl_d)
        || (msg_take && LOCAL_MSG_NMI_IN);

    // Event qualification for the current boundary
    assign take = BOUNDARY_IN && (cur.st == iev_pkg::ST_IDLE);
    assign ve_fault = EPT_VIOLATION_IN && VE_ENABLE_IN;
    assign hw_fault = MATH_ERR_IN || ALIGN_ERR_IN || SIMD_ERR_IN || ve_fault;
    assign sw_kind = iev_pkg::iev_sw_kind_e'(SW_INT_KIND_IN);
    assign sw_evt = SW_INT_VALID_IN && ((sw_kind == iev_pkg::SW_INT_N)
        || (sw_kind == iev_pkg::SW_INT3) || SW_CHECK_FAIL_IN);
    // Pin path is used only when no local controller is active
    assign pin_req = !local_mode && pins.lvl[iev_pkg::PIN_MASKABLE_REQUEST_PIN];

    // Fixed priority: abort, instruction faults, software, NMI, maskable.
    // The interrupt-enable flag gates only the last two grants.
    assign g_mc = take && MACHINE_CHECK_IN;
    assign g_fault = take && !MACHINE_CHECK_IN && hw_fault;
    assign g_sw = take && !MACHINE_CHECK_IN && !hw_fault && sw_evt;
    assign g_nmi = take && !MACHINE_CHECK_IN && !hw_fault && !sw_evt
        && cur.nmi_pend;
    assign g_loc = take && !MACHINE_CHECK_IN && !hw_fault && !sw_evt
        && !cur.nmi_pend && IF_FLAG_IN && cur.loc_pend;
    assign g_pin = take && !MACHINE_CHECK_IN && !hw_fault && !sw_evt
        && !cur.nmi_pend && IF_FLAG_IN && !cur.loc_pend && pin_req;

    // Next state: pulses default low, data outputs hold between dispatches
    always_comb begin
        next_cur = cur;
        next_cur.disp_valid = 1'b0;
        next_cur.nmi_hw = 1'b0;
        next_cur.inta = 1'b0;
        next_cur.illegal = msg_illegal;
        // Side pins are passed on and never reach the dispatch logic
        next_cur.sideband = SIDEBAND_REQ_IN;
        next_cur.nmi_lvl_d = pins.lvl[iev_pkg::PIN_NMI];
        // A new NMI in the cycle the old one is taken stays pending
        next_cur.nmi_pend = (cur.nmi_pend && !g_nmi) || nmi_set;
        // Masked requests wait here until taken at a later boundary
        if (msg_maskable) begin
            next_cur.loc_pend = 1'b1;
            next_cur.loc_vec = LOCAL_MSG_VECTOR_IN;
        end else if (g_loc) begin
            next_cur.loc_pend = 1'b0;
        end
        if (g_mc || g_fault || g_sw || g_nmi || g_loc) begin
            next_cur.disp_valid = 1'b1;
            next_cur.push_err = 1'b0;
            next_cur.err_code = iev_pkg::ERR_RESET;
        end
        if (g_mc) begin
            next_cur.disp_vec = iev_pkg::VEC_MCHECK;
            next_cur.disp_class = iev_pkg::CLS_ABORT;
            next_cur.push_err = MC_ERR_CODE_VALID_IN;
            next_cur.err_code = MC_ERR_CODE_IN;
        end else if (g_fault) begin
            next_cur.disp_class = iev_pkg::CLS_FAULT;
            if (MATH_ERR_IN) begin
                next_cur.disp_vec = iev_pkg::VEC_MATH;
            end else if (ALIGN_ERR_IN) begin
                next_cur.disp_vec = iev_pkg::VEC_ALIGN;
                next_cur.push_err = 1'b1;
                next_cur.err_code = iev_pkg::ERR_CODE_ALIGN;
            end else if (SIMD_ERR_IN) begin
                next_cur.disp_vec = iev_pkg::VEC_SIMD;
            end else begin
                next_cur.disp_vec = iev_pkg::VEC_VIRT;
            end
        end else if (g_sw) begin
            case (sw_kind)
                iev_pkg::SW_INT_N: begin
                    // Any vector, no error code, no NMI hardware
                    next_cur.disp_vec = SW_INT_VECTOR_IN;
                    next_cur.disp_class = iev_pkg::CLS_MASKABLE_REQUEST_PIN;
                end
                iev_pkg::SW_INT3: begin
                    next_cur.disp_vec = iev_pkg::VEC_BREAKPOINT;
                    next_cur.disp_class = iev_pkg::CLS_TRAP;
                end
                iev_pkg::SW_INTO: begin
                    next_cur.disp_vec = iev_pkg::VEC_OVERFLOW;
                    next_cur.disp_class = iev_pkg::CLS_TRAP;
                end
                default: begin
                    next_cur.disp_vec = iev_pkg::VEC_BOUND;
                    next_cur.disp_class = iev_pkg::CLS_FAULT;
                end
            endcase
        end else if (g_nmi) begin
            next_cur.disp_vec = iev_pkg::VEC_NMI;
            next_cur.disp_class = iev_pkg::CLS_MASKABLE_REQUEST_PIN;
            next_cur.nmi_hw = 1'b1;
        end else if (g_loc) begin
            // Reserved vectors from a source are passed on as interrupts
            next_cur.disp_vec = cur.loc_vec;
            next_cur.disp_class = iev_pkg::CLS_MASKABLE_REQUEST_PIN;
        end
        case (cur.st)
            iev_pkg::ST_IDLE: begin
                if (g_pin) begin
                    next_cur.inta = 1'b1;
                    next_cur.st = iev_pkg::ST_WAIT_VEC;
                end
            end
            iev_pkg::ST_WAIT_VEC: begin
                // Pin path carries any vector 0 to 255 unchecked
                if (EXT_VECTOR_VALID_IN) begin
                    next_cur.disp_valid = 1'b1;
                    next_cur.disp_vec = EXT_VECTOR_IN;
                    next_cur.disp_class = iev_pkg::CLS_MASKABLE_REQUEST_PIN;
                    next_cur.push_err = 1'b0;
                    next_cur.err_code = iev_pkg::ERR_RESET;
                    next_cur.st = iev_pkg::ST_IDLE;
                end
            end
            default: begin
                next_cur.st = iev_pkg::ST_IDLE;
            end
        endcase
        // Faults return to the faulting instruction itself
        next_cur.restart_fault = (next_cur.disp_class == iev_pkg::CLS_FAULT)
            && (next_cur.disp_valid || cur.restart_fault);
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            cur <= CORE_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register, except LOCAL_MSG_READY_OUT which also uses LOCAL_CTRL_ENABLE_IN
    assign DISPATCH_VALID_OUT = cur.disp_valid;
    assign DISPATCH_VECTOR_OUT = cur.disp_vec;
    assign DISPATCH_CLASS_OUT = cur.disp_class;
    assign PUSH_ERR_CODE_OUT = cur.push_err;
    assign ERR_CODE_OUT = cur.err_code;
    assign RESTART_AT_FAULT_OUT = cur.restart_fault;
    assign NMI_HW_OUT = cur.nmi_hw;
    assign INTA_OUT = cur.inta;
    assign BUSY_OUT = (cur.st != iev_pkg::ST_IDLE);
    assign LOCAL_MSG_READY_OUT = msg_ready;
    assign ILLEGAL_VECTOR_OUT = cur.illegal;
    assign SIDEBAND_OUT = cur.sideband;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    sequence s_fetch_start;
        INTA_OUT && BUSY_OUT;
    endsequence

    sequence s_fetch_done;
        EXT_VECTOR_VALID_IN ##1 (DISPATCH_VALID_OUT && !BUSY_OUT);
    endsequence

    fault_no_err_a: assert property (
        (g_fault && !ALIGN_ERR_IN) |=> (!PUSH_ERR_CODE_OUT
        && (DISPATCH_CLASS_OUT == iev_pkg::CLS_FAULT)))
        else $error("math, simd or virtualization fault pushed a code");
    align_code_a: assert property (
        (g_fault && !MATH_ERR_IN && ALIGN_ERR_IN) |=> (DISPATCH_VALID_OUT
        && (DISPATCH_VECTOR_OUT == 8'h11) && PUSH_ERR_CODE_OUT
        && (ERR_CODE_OUT == 32'h0000_0000)))
        else $error("alignment fault vector or error code wrong");
    virt_gate_a: assert property (
        (DISPATCH_VALID_OUT && (DISPATCH_VECTOR_OUT == 8'h14)
        && (DISPATCH_CLASS_OUT == iev_pkg::CLS_FAULT)) |-> $past(VE_ENABLE_IN))
        else $error("virtualization fault raised while disabled");
    mc_abort_a: assert property (
        g_mc |=> (DISPATCH_VALID_OUT && (DISPATCH_VECTOR_OUT == 8'h12)
        && (DISPATCH_CLASS_OUT == iev_pkg::CLS_ABORT) && !RESTART_AT_FAULT_OUT))
        else $error("machine check not reported as abort on 18");
    if_mask_a: assert property (
        (take && !IF_FLAG_IN && !MACHINE_CHECK_IN && !hw_fault && !sw_evt
        && !cur.nmi_pend) |=> (!DISPATCH_VALID_OUT && !INTA_OUT))
        else $error("maskable interrupt taken with flag clear");
    illegal_vec_a: assert property (
        msg_illegal |=> (ILLEGAL_VECTOR_OUT && !cur.loc_pend))
        else $error("low vector from local controller not flagged");
    swint_vec_a: assert property (
        (g_sw && (sw_kind == iev_pkg::SW_INT_N)) |=> (DISPATCH_VALID_OUT
        && (DISPATCH_VECTOR_OUT == $past(SW_INT_VECTOR_IN))
        && !PUSH_ERR_CODE_OUT))
        else $error("software interrupt vector lost or pushed a code");
    sw_nmi_a: assert property (
        (g_sw && (sw_kind == iev_pkg::SW_INT_N) && (SW_INT_VECTOR_IN == 8'h02))
        |=> !NMI_HW_OUT)
        else $error("software vector 2 engaged nonmaskable hardware");
    user_class_a: assert property (
        (DISPATCH_VALID_OUT && (DISPATCH_VECTOR_OUT >= 8'h20))
        |-> (DISPATCH_CLASS_OUT == iev_pkg::CLS_MASKABLE_REQUEST_PIN))
        else $error("user vector dispatched with wrong class");
    pin_fetch_a: assert property (
        g_pin |=> s_fetch_start ##1 !INTA_OUT)
        else $error("vector fetch sequence broken");
    fetch_vec_a: assert property (
        (BUSY_OUT && EXT_VECTOR_VALID_IN) |-> s_fetch_done
        ##0 (DISPATCH_VECTOR_OUT == $past(EXT_VECTOR_IN)))
        else $error("fetched vector not dispatched next cycle");
    nmi_vec_a: assert property (
        NMI_HW_OUT |-> (DISPATCH_VALID_OUT && (DISPATCH_VECTOR_OUT == 8'h02)))
        else $error("true NMI delivered on a vector other than 2");
    restart_a: assert property (
        (DISPATCH_VALID_OUT && (DISPATCH_CLASS_OUT == iev_pkg::CLS_FAULT))
        |-> RESTART_AT_FAULT_OUT)
        else $error("fault dispatched without restart marking");
    pend_hold_a: assert property (
        (cur.loc_pend && !IF_FLAG_IN) |=> cur.loc_pend)
        else $error("masked local request dropped");
    side_pass_a: assert property (
        (take && (SIDEBAND_REQ_IN != 6'h00) && !(g_mc || g_fault || g_sw
        || g_nmi || g_loc || g_pin)) |=> (!DISPATCH_VALID_OUT
        && (SIDEBAND_OUT == $past(SIDEBAND_REQ_IN))))
        else $error("side pin event entered vector dispatch");

endmodule : iev_core

`default_nettype wire

/* File: rtl/iev_pin_if.sv */
// Carrier between the core unit and its pin synchroniser.
// Assumes both ends run on the core clock; raw levels are asynchronous.
`default_nettype none

interface iev_pin_if #(
    parameter int W = 2
);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;

    modport syncer (input raw, output lvl);
    modport core (output raw, input lvl);
endinterface : iev_pin_if

`default_nettype wire

/* File: rtl/iev_pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes raw pins may change at any time relative to the core clock.
`default_nettype none

module iev_pin_sync #(
    parameter int W = 2
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    iev_pin_if.syncer pins
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } iev_sync_s;

    localparam iev_sync_s SYNC_RST = '0;

    iev_sync_s cur;
    iev_sync_s next_cur;
    logic [W-1:0] agree;

    // Only stages two and three are compared; stage one may be metastable
    assign agree = ~(cur.s2 ^ cur.s3);
    assign pins.lvl = cur.lvl;

    // Shift chain, level follows once the last two stages agree
    always_comb begin
        next_cur = cur;
        next_cur.s1 = pins.raw;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        next_cur.lvl = (cur.lvl & ~agree) | (cur.s2 & agree);
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cur <= SYNC_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // The filtered level never moves without the last two stages agreeing
    sync_agree_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cur.lvl != $past(cur.lvl)) |-> ($past(cur.s2) == $past(cur.s3)))
        else $error("synchronised level moved without agreement");

endmodule : iev_pin_sync

`default_nettype wire

/* File: rtl/iev_pkg.sv */
// Shared constants and types for the exception vector source unit.
// Assumes a single core clock domain; every user writes iev_pkg::name.
`default_nettype none

package iev_pkg;

    // Widths
    localparam int VEC_W = 8;
    localparam int ERR_W = 32;
    localparam int SIDEBAND_W = 6;

    // Architecturally fixed vector numbers
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
    localparam logic [7:0] VEC_OVERFLOW = 8'h04;
    localparam logic [7:0] VEC_BOUND = 8'h05;
    localparam logic [7:0] VEC_MATH = 8'h10;
    localparam logic [7:0] VEC_ALIGN = 8'h11;
    localparam logic [7:0] VEC_MCHECK = 8'h12;
    localparam logic [7:0] VEC_SIMD = 8'h13;
    localparam logic [7:0] VEC_VIRT = 8'h14;
    localparam logic [7:0] VEC_RSV_LO = 8'h15;
    localparam logic [7:0] VEC_RSV_HI = 8'h1F;
    localparam logic [7:0] VEC_USER_LO = 8'h20;
    localparam logic [7:0] VEC_LOCAL_MIN = 8'h10;

    // Error code values and reset values
    localparam logic [31:0] ERR_CODE_ALIGN = 32'h0000_0000;
    localparam logic [31:0] ERR_RESET = 32'h0000_0000;
    localparam logic [7:0] VEC_RESET = 8'h00;

    // Pin synchroniser depth and pin slots
    localparam int SYNC_STAGES = 3;
    localparam int PIN_MASKABLE_REQUEST_PIN = 0;
    localparam int PIN_NMI = 1;
    localparam int PIN_COUNT = 2;

    // Delivery class reported with each dispatch
    typedef enum logic [1:0] {
        CLS_FAULT,
        CLS_TRAP,
        CLS_ABORT,
        CLS_MASKABLE_REQUEST_PIN
    } iev_class_e;

    // Kind of software event offered at a boundary
    typedef enum logic [1:0] {
        SW_INT_N,
        SW_INT3,
        SW_INTO,
        SW_BOUND
    } iev_sw_kind_e;

    typedef enum logic {
        ST_IDLE,
        ST_WAIT_VEC
    } iev_state_e;

    // Whole state of the core unit
    typedef struct packed {
        iev_state_e st;
        logic nmi_pend;
        logic nmi_lvl_d;
        logic loc_pend;
        logic [VEC_W-1:0] loc_vec;
        logic disp_valid;
        logic [VEC_W-1:0] disp_vec;
        iev_class_e disp_class;
        logic push_err;
        logic [ERR_W-1:0] err_code;
        logic restart_fault;
        logic nmi_hw;
        logic inta;
        logic illegal;
        logic [SIDEBAND_W-1:0] sideband;
    } iev_state_s;

endpackage : iev_pkg

`default_nettype wire

/* File: verif/iev_ext_ctrl.sv */
// Far-side interrupt controller model: answers each fetch pulse.
// Assumes the core clock; the vector line is only valid with valid_out.
`default_nettype none

module iev_ext_ctrl (
    input wire logic clk_in,
    input wire logic inta_in,
    input wire logic [7:0] vec_in,
    input wire logic [3:0] wait_in,
    output logic valid_out,
    output logic [7:0] vec_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = -1;

    initial begin
        valid_out = 1'b0;
        vec_out = 8'h00;
    end

    // Count down after a fetch pulse, then offer the vector for one cycle
    // Outside that cycle the bus toggles so a stale value is never seen
    always @(posedge clk_in) begin
        if (inta_in) cnt <= int'(wait_in);
        else if (cnt >= 0) cnt <= cnt - 1;
        valid_out <= (cnt == 0);
        vec_out <= (cnt == 0) ? vec_in : ~vec_out;
    end
endmodule : iev_ext_ctrl

`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the exception vector source unit.
// Assumes the partner controller model and a single 5 ns core clock.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, bnd = 1'b0, ifl = 1'b0, pin = 1'b0;
    logic nmi = 1'b0, lce = 1'b1, mv = 1'b0, mn = 1'b0, sv = 1'b0;
    logic sf = 1'b0, me = 1'b0, ae = 1'b0, se = 1'b0, extended_page_table = 1'b0;
    logic ve = 1'b0, mc = 1'b0, mcv = 1'b0, ext_v;
    logic dv, dpush, drs, nhw, inta, busy, rdy, ill;
    logic [1:0] sk = 2'h0, dcls;
    logic [3:0] pwait = 4'h0;
    logic [5:0] sb = 6'h00, sb_prev = 6'h00, sbo;
    logic [7:0] mvec = 8'h00, svec = 8'h00, pvec = 8'h00, dvec, ext_vec, v;
    logic [31:0] mcc = 32'h0, dcode, r;
    logic [7:0] fv [5] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h12};
    logic [7:0] tv [4] = '{8'h02, 8'h0D, 8'h11, 8'h23};
    int bad_count = 0, total_checks = 0, cycles = 0, seed = 32'h3a87;
    wire [45:0] got = {dv, dvec, dcls, dpush, dcode, drs, nhw};

    iev_core dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .BOUNDARY_IN(bnd),
        .IF_FLAG_IN(ifl), .MASKABLE_REQUEST_PIN_IN(pin), .NMI_PIN_IN(nmi),
        .EXT_VECTOR_IN(ext_vec), .EXT_VECTOR_VALID_IN(ext_v),
        .LOCAL_CTRL_ENABLE_IN(lce), .LOCAL_MSG_VALID_IN(mv),
        .LOCAL_MSG_NMI_IN(mn), .LOCAL_MSG_VECTOR_IN(mvec),
        .SW_INT_VALID_IN(sv), .SW_INT_KIND_IN(sk), .SW_INT_VECTOR_IN(svec),
        .SW_CHECK_FAIL_IN(sf), .MATH_ERR_IN(me), .ALIGN_ERR_IN(ae),
        .SIMD_ERR_IN(se), .EPT_VIOLATION_IN(extended_page_table), .VE_ENABLE_IN(ve),
        .MACHINE_CHECK_IN(mc), .MC_ERR_CODE_VALID_IN(mcv),
        .MC_ERR_CODE_IN(mcc), .SIDEBAND_REQ_IN(sb),
        .DISPATCH_VALID_OUT(dv), .DISPATCH_VECTOR_OUT(dvec),
        .DISPATCH_CLASS_OUT(dcls), .PUSH_ERR_CODE_OUT(dpush),
        .ERR_CODE_OUT(dcode), .RESTART_AT_FAULT_OUT(drs), .NMI_HW_OUT(nhw),
        .INTA_OUT(inta), .BUSY_OUT(busy), .LOCAL_MSG_READY_OUT(rdy),
        .ILLEGAL_VECTOR_OUT(ill), .SIDEBAND_OUT(sbo));

    iev_ext_ctrl ctrl (.clk_in(clk), .inta_in(inta), .vec_in(pvec),
        .wait_in(pwait), .valid_out(ext_v), .vec_out(ext_vec));

    always #2.5 clk = ~clk;

    // Expected dispatch word; restart marking follows the fault class
    function automatic logic [45:0] ex(input logic [7:0] vv,
        input logic [1:0] c, input logic p, input logic [31:0] e,
        input logic n);
        return {1'b1, vv, c, p, p ? e : 32'h0, c == 2'h0, n};
    endfunction : ex

    task automatic chk(input logic [45:0] g, input logic [45:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One boundary; the error code is only compared when it is pushed
    task automatic step(input logic [45:0] e);
        logic [45:0] g;
        bnd <= 1'b1;
        @(posedge clk);
        {bnd, sv, sf, me, ae, se, extended_page_table, mc} <= '0;
        @(negedge clk);
        g = e[45] ? got : 46'(dv);
        if (!e[34]) g[33:2] = '0;
        chk(g, e);
        @(posedge clk);
    endtask : step

    // One local message; e is the expected {illegal, ready} pair
    task automatic msg(input logic [7:0] vv, input logic n,
        input logic [1:0] e);
        {mv, mn, mvec} <= {1'b1, n, vv};
        @(posedge clk);
        mv <= 1'b0;
        @(negedge clk);
        chk(46'({ill, rdy}), 46'(e));
        @(posedge clk);
    endtask : msg

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Cycle limit and random side pins, which must never dispatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        sb_prev = sb;
        sb <= 6'($random(seed));
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end

    always @(negedge clk)
        if (cycles > 10) chk(46'(sbo), 46'(sb_prev));

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ve <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            {mcc, mcv} <= {r, r[0]};
            {me, ae, se, extended_page_table, mc} <= 5'h10 >> i;
            step(ex(fv[i], (i == 4) ? 2'h2 : 2'h0, i == 1 || (i == 4 && r[0]),
                (i == 4) ? r : 32'h0, 1'b0));
        end
        {ve, extended_page_table} <= 2'b01;
        step(46'h0);
        // Software events with the enable flag clear are still taken
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? tv[i] : 8'($random(seed));
            if (v >= 8'h15 && v <= 8'h1F) v = v + 8'h10;
            {sv, sk, svec} <= {1'b1, 2'h0, v};
            step(ex(v, 2'h3, 1'b0, 32'h0, 1'b0));
        end
        for (int k = 1; k < 4; k++) begin
            {sv, sk, sf} <= {1'b1, 2'(k), 1'b1};
            step(ex(8'(k + 2), (k == 3) ? 2'h0 : 2'h1, 1'b0, 32'h0, 1'b0));
        end
        {sv, sk} <= {1'b1, 2'h2};
        step(46'h0);
        nmi <= 1'b1;
        repeat (6) @(posedge clk);
        step(ex(8'h02, 2'h3, 1'b0, 32'h0, 1'b1));
        msg(8'h05, 1'b0, 2'h3);
        msg(8'h40, 1'b0, 2'h0);
        step(46'h0);
        ifl <= 1'b1;
        step(ex(8'h40, 2'h3, 1'b0, 32'h0, 1'b0));
        msg(8'h00, 1'b1, 2'h1);
        step(ex(8'h02, 2'h3, 1'b0, 32'h0, 1'b1));
        // Pin path, with a prompt and then a slow controller
        {lce, pin} <= 2'b01;
        for (int w = 0; w < 4; w += 3) begin
            // Controller inputs change only just after a rising edge
            @(posedge clk);
            v = 8'($random(seed));
            if (v >= 8'h15 && v <= 8'h1F) v = v + 8'h10;
            {pvec, pwait} <= {v, 4'(w)};
            repeat (5) @(posedge clk);
            bnd <= 1'b1;
            @(posedge clk);
            bnd <= 1'b0;
            @(negedge clk);
            chk(46'({inta, busy}), 46'h3);
            for (int n = 0; n < 20 && dv !== 1'b1; n++) @(negedge clk);
            chk(got & ~46'h3_FFFF_FFFC, ex(v, 2'h3, 1'b0, 32'h0, 1'b0));
        end
        @(posedge clk);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
